// ### rtl/mpmo_fifo_if.sv
// signals between the pulse logic and the sign-bit fifo
`timescale 1ns/1ps
interface mpmo_fifo_if;
	logic push;
	logic [1:0] push_data;
	logic full;
	logic pop;
	logic [1:0] pop_data;
	logic pop_valid;
	logic empty;
	logic [2:0] level;

	modport store (
		input push, push_data, pop,
		output full, pop_data, pop_valid, empty, level
	);
	modport user (
		output push, push_data, pop,
		input full, pop_data, pop_valid, empty, level
	);
endinterface

// ### rtl/mpmo_pkg.sv
// constants and types shared by the metering pulse and monitor output block
package mpmo_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MON_ADDR0 = 8'h04;
	localparam logic [7:0] REG_MON_ADDR1 = 8'h08;
	localparam logic [7:0] REG_MON_ADDR2 = 8'h0C;
	localparam logic [7:0] REG_MON_ADDR3 = 8'h10;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h1C;
	localparam logic [7:0] REG_PULSE_STATE = 8'h20;

	// ==========================================================
	// control register fields and reset values
	localparam int CTRL_MON_EN_BIT = 0;
	localparam int CTRL_INV_BIT = 1;
	localparam int CTRL_FORMULA_LSB = 2;
	localparam logic RST_MON_EN = 1'h0;
	localparam logic RST_INV = 1'h0;

	// ==========================================================
	// meter formula codes
	localparam logic [2:0] FORMULA_2E_3W_DELTA = 3'h2;
	localparam logic [2:0] FORMULA_2E_4W_DELTA = 3'h3;
	localparam logic [2:0] FORMULA_2E_4W_WYE = 3'h4;
	localparam logic [2:0] FORMULA_3E_4W_WYE = 3'h5;
	localparam logic [2:0] RST_FORMULA = FORMULA_3E_4W_WYE;

	// ==========================================================
	// live word monitor
	localparam int MON_WORDS = 4;
	localparam int MON_DATA_BITS = 32;
	localparam int RAM_AW = 12;
	localparam logic [5:0] MON_BITS_PER_WORD = 6'h23;
	localparam logic [5:0] MON_LAST_BIT = 6'h22;
	localparam logic [2:0] MON_FETCH_LAST = 3'h5;
	localparam logic [2:0] MON_FETCH_CAP = 3'h2;
	localparam logic [2:0] MON_FETCH_ISSUES = 3'h4;
	localparam int ENGINE_CLK_PERIOD_NS = 203;

	// ==========================================================
	// pulse generators and sign-bit fifo
	localparam int PULSE_REACTIVE = 0;
	localparam int PULSE_REAL = 1;
	localparam int PULSE_THIRD = 2;
	localparam int PULSE_FOURTH = 3;
	localparam int IRQ_OVERFLOW = 4;
	localparam int IRQ_W = 5;
	localparam int SIGN_FIFO_BITS = 8;
	localparam int SIGN_ENTRY_BITS = 2;
	localparam int SIGN_FIFO_DEPTH = SIGN_FIFO_BITS / SIGN_ENTRY_BITS;
	localparam int REF_CLK_PERIOD_NS = 8;
	localparam int SIGN_SLOT_NS = 1000;
	localparam int SIGN_SLOT_CYCLES_I = SIGN_SLOT_NS / REF_CLK_PERIOD_NS;
	localparam logic [7:0] SIGN_SLOT_LAST = 8'(SIGN_SLOT_CYCLES_I - 1);

	typedef enum logic [1:0] {
		MON_IDLE,
		MON_FETCH,
		MON_SHIFT
	} mpmo_mon_state_e;

endpackage

// ### rtl/mpmo_sign_fifo.sv
// eight-bit fifo of real/reactive sign pairs with registered read data
`timescale 1ns/1ps
module mpmo_sign_fifo
	import mpmo_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// fifo ports
	mpmo_fifo_if.store f
);
	logic [1:0] mem [SIGN_FIFO_DEPTH];
	logic [1:0] wp;
	logic [1:0] rp;
	logic [2:0] count;
	logic do_push;
	logic do_pop;

	assign do_push = f.push && !f.full;
	assign do_pop = f.pop && !f.empty;
	assign f.full = (count == 3'(SIGN_FIFO_DEPTH));
	assign f.empty = (count == 3'h0);
	assign f.level = count;

	// ==========================================================
	// storage
	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			mem[wp] <= f.push_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wp <= 2'h0;
			rp <= 2'h0;
			count <= 3'h0;
		end else begin
			if (do_push) begin
				wp <= wp + 2'h1;
			end
			if (do_pop) begin
				rp <= rp + 2'h1;
			end
			count <= 3'(count + {2'h0, do_push} - {2'h0, do_pop});
		end
	end

	// ==========================================================
	// registered read port
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			f.pop_data <= 2'h0;
			f.pop_valid <= 1'h0;
		end else begin
			f.pop_valid <= do_pop;
			if (do_pop) begin
				f.pop_data <= mem[rp];
			end
		end
	end

	overflow_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
		(f.push && f.full && !f.pop) |=> (count == $past(count)))
		else $error("fifo level changed on push into full fifo");

endmodule // mpmo_sign_fifo

// ### rtl/mpmo_top.sv
// live word monitor, formula select, four pulse outputs and interrupt
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module mpmo_top
	import mpmo_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// compute engine side
	input wire logic pass_start,
	input wire logic sign_valid,
	input wire logic sign_real,
	input wire logic sign_reactive,
	input wire logic third_pulse_req,
	input wire logic fourth_pulse_req,
	output logic [2:0] meter_formula_select,
	// shared data ram read port, data valid the cycle after the strobe
	output logic ram_rd,
	output logic [RAM_AW-1:0] ram_addr,
	input wire logic [31:0] ram_rdata,
	// test equipment
	input wire logic engine_clock,
	output logic test_output_pin,
	output logic test_clock,
	// pulse pins
	output logic real_energy_output,
	output logic reactive_energy_output,
	output logic multipurpose_pin_six,
	output logic multipurpose_pin_seven,
	// interrupt
	output logic irq
);
	function automatic logic mon_bit(input logic [31:0] w, input logic [5:0] cnt);
		logic b;
		b = 1'h0;
		if (cnt == 6'h00) begin
			b = 1'h1;
		end else if (cnt <= 6'(MON_DATA_BITS)) begin
			b = w[5'(6'(MON_DATA_BITS) - cnt)];
		end
		return b;
	endfunction

	logic monitor_enable;
	logic pulse_polarity_invert;
	logic [RAM_AW-1:0] mon_addr [MON_WORDS];
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_event;
	logic [3:0] pulse_act;
	logic [3:0] pulse_act_q;
	logic ck_s1;
	logic ck_s2;
	logic ck_s3;
	logic ck_rise;
	mpmo_mon_state_e mon_state;
	logic [2:0] fetch_cnt;
	logic [31:0] mon_word [MON_WORDS];
	logic [1:0] word_idx;
	logic [5:0] bit_cnt;
	logic [7:0] slot_cnt;
	logic slot_tick;
	logic fifo_overflow;
	logic [2:0] next_formula;
	logic [31:0] next_rdata;

	mpmo_fifo_if fif ();

	mpmo_sign_fifo u_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.f(fif)
	);

	// ==========================================================
	// register writes
	assign next_formula = reg_wdata[CTRL_FORMULA_LSB +: 3];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			monitor_enable <= RST_MON_EN;
			pulse_polarity_invert <= RST_INV;
			meter_formula_select <= RST_FORMULA;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			monitor_enable <= reg_wdata[CTRL_MON_EN_BIT];
			pulse_polarity_invert <= reg_wdata[CTRL_INV_BIT];
			if (next_formula >= FORMULA_2E_3W_DELTA && next_formula <= FORMULA_3E_4W_WYE) begin
				meter_formula_select <= next_formula;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < MON_WORDS; i++) begin
				mon_addr[i] <= '0;
			end
		end else if (reg_wr) begin
			for (int i = 0; i < MON_WORDS; i++) begin
				if (reg_addr == 8'(REG_MON_ADDR0 + 8'(4 * i))) begin
					mon_addr[i] <= reg_wdata[RAM_AW-1:0];
				end
			end
		end
	end

	// ==========================================================
	// register reads
	always_comb begin
		next_rdata = 32'h0;
		case (reg_addr)
			REG_CTRL: next_rdata = {27'h0, meter_formula_select, pulse_polarity_invert,
				monitor_enable};
			REG_MON_ADDR0: next_rdata = {20'h0, mon_addr[0]};
			REG_MON_ADDR1: next_rdata = {20'h0, mon_addr[1]};
			REG_MON_ADDR2: next_rdata = {20'h0, mon_addr[2]};
			REG_MON_ADDR3: next_rdata = {20'h0, mon_addr[3]};
			REG_IRQ_STATUS: next_rdata = {27'h0, irq_status};
			REG_IRQ_ENABLE: next_rdata = {27'h0, irq_enable};
			REG_PULSE_STATE: next_rdata = {20'h0, mon_state != MON_IDLE, fif.level,
				multipurpose_pin_seven, multipurpose_pin_six, real_energy_output,
				reactive_energy_output, pulse_act};
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
		end
	end

	// ==========================================================
	// engine clock synchroniser and edge finder
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ck_s1 <= 1'h0;
			ck_s2 <= 1'h0;
			ck_s3 <= 1'h0;
		end else begin
			ck_s1 <= engine_clock;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
		end
	end
	assign ck_rise = ck_s2 && !ck_s3;

	// ==========================================================
	// live word monitor
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mon_state <= MON_IDLE;
			fetch_cnt <= 3'h0;
			word_idx <= 2'h0;
			bit_cnt <= 6'h0;
		end else if (!monitor_enable) begin
			mon_state <= MON_IDLE;
		end else begin
			case (mon_state)
				MON_IDLE: begin
					fetch_cnt <= 3'h0;
					word_idx <= 2'h0;
					bit_cnt <= 6'h0;
					if (pass_start) begin
						mon_state <= MON_FETCH;
					end
				end
				MON_FETCH: begin
					fetch_cnt <= fetch_cnt + 3'h1;
					if (fetch_cnt == MON_FETCH_LAST) begin
						mon_state <= MON_SHIFT;
					end
				end
				MON_SHIFT: begin
					if (ck_rise) begin
						if (bit_cnt == MON_LAST_BIT) begin
							bit_cnt <= 6'h0;
							word_idx <= word_idx + 2'h1;
							if (word_idx == 2'(MON_WORDS - 1)) begin
								mon_state <= MON_IDLE;
							end
						end else begin
							bit_cnt <= bit_cnt + 6'h1;
						end
					end
				end
				default: mon_state <= MON_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ram_rd <= 1'h0;
			ram_addr <= '0;
		end else begin
			ram_rd <= (mon_state == MON_FETCH) && (fetch_cnt < MON_FETCH_ISSUES);
			ram_addr <= mon_addr[fetch_cnt[1:0]];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (mon_state == MON_FETCH && fetch_cnt >= MON_FETCH_CAP) begin
			mon_word[2'(fetch_cnt - MON_FETCH_CAP)] <= ram_rdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			test_output_pin <= 1'h0;
			test_clock <= 1'h0;
		end else if (!monitor_enable || mon_state != MON_SHIFT) begin
			test_output_pin <= 1'h0;
			test_clock <= 1'h0;
		end else begin
			// only a detected rise opens a test clock pulse, so no stray fall before the flag
			test_clock <= ck_s2 && (test_clock || ck_rise);
			if (ck_rise) begin
				test_output_pin <= mon_bit(mon_word[word_idx], bit_cnt);
			end
		end
	end

	mon_stop_a: assert property (@(posedge ref_clk) disable iff (srst)
		!monitor_enable |=> (mon_state == MON_IDLE) ##1 !test_output_pin)
		else $error("monitor still active after enable cleared");
	mon_start_a: assert property (@(posedge ref_clk) disable iff (srst)
		(monitor_enable && pass_start && mon_state == MON_IDLE) |=> (mon_state == MON_FETCH)
			##6 (mon_state == MON_SHIFT) || !monitor_enable)
		else $error("monitor did not start on pass");
	flag_bit_a: assert property (@(posedge ref_clk) disable iff (srst)
		(monitor_enable && mon_state == MON_SHIFT && ck_rise && bit_cnt == 6'h00)
			|=> test_output_pin)
		else $error("monitor word lacks leading flag");
	word_len_a: assert property (@(posedge ref_clk) disable iff (srst)
		bit_cnt < MON_BITS_PER_WORD)
		else $error("monitor bit count passed word length");

	// ==========================================================
	// pulse generators
	assign slot_tick = (slot_cnt == SIGN_SLOT_LAST);
	assign fif.push = sign_valid;
	assign fif.push_data = {sign_real, sign_reactive};
	assign fif.pop = slot_tick;
	assign fifo_overflow = sign_valid && fif.full;

	always_ff @(posedge ref_clk) begin
		if (srst || slot_tick) begin
			slot_cnt <= 8'h0;
		end else begin
			slot_cnt <= slot_cnt + 8'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pulse_act <= 4'h0;
		end else begin
			if (pass_start) begin
				pulse_act[PULSE_THIRD] <= third_pulse_req;
				pulse_act[PULSE_FOURTH] <= fourth_pulse_req;
			end
			if (fif.pop_valid) begin
				pulse_act[PULSE_REAL] <= fif.pop_data[1];
				pulse_act[PULSE_REACTIVE] <= fif.pop_data[0];
			end else if (slot_tick && fif.empty) begin
				pulse_act[PULSE_REAL] <= 1'h0;
				pulse_act[PULSE_REACTIVE] <= 1'h0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reactive_energy_output <= !RST_INV;
			real_energy_output <= !RST_INV;
			multipurpose_pin_six <= !RST_INV;
			multipurpose_pin_seven <= !RST_INV;
		end else begin
			reactive_energy_output <= !(pulse_act[PULSE_REACTIVE] ^ pulse_polarity_invert);
			real_energy_output <= !(pulse_act[PULSE_REAL] ^ pulse_polarity_invert);
			multipurpose_pin_six <= !(pulse_act[PULSE_THIRD] ^ pulse_polarity_invert);
			multipurpose_pin_seven <= !(pulse_act[PULSE_FOURTH] ^ pulse_polarity_invert);
		end
	end

	xy_once_a: assert property (@(posedge ref_clk) disable iff (srst)
		!pass_start |=> $stable(pulse_act[PULSE_FOURTH:PULSE_THIRD]))
		else $error("third or fourth pulse changed outside pass start");
	polarity_a: assert property (@(posedge ref_clk) disable iff (srst)
		##1 (multipurpose_pin_six == ($past(pulse_polarity_invert) ? $past(pulse_act[PULSE_THIRD])
			: !$past(pulse_act[PULSE_THIRD]))))
		else $error("pulse pin polarity wrong");
	empty_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
		(slot_tick && fif.empty) |=> !pulse_act[PULSE_REAL] && !pulse_act[PULSE_REACTIVE])
		else $error("pulse active with empty sign fifo");
	formula_range_a: assert property (@(posedge ref_clk) disable iff (srst)
		meter_formula_select >= FORMULA_2E_3W_DELTA && meter_formula_select <= FORMULA_3E_4W_WYE)
		else $error("formula select holds undefined code");

	// ==========================================================
	// interrupt status, enable and clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pulse_act_q <= 4'h0;
		end else begin
			pulse_act_q <= pulse_act;
		end
	end
	assign irq_event = {fifo_overflow, pulse_act & ~pulse_act_q};

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_status <= '0;
		end else if (reg_wr && reg_addr == REG_IRQ_CLEAR) begin
			irq_status <= (irq_status & ~reg_wdata[IRQ_W-1:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_enable <= '0;
			irq <= 1'h0;
		end else begin
			if (reg_wr && reg_addr == REG_IRQ_ENABLE) begin
				irq_enable <= reg_wdata[IRQ_W-1:0];
			end
			irq <= |(irq_status & irq_enable);
		end
	end

	irq_raise_a: assert property (@(posedge ref_clk) disable iff (srst)
		(|(irq_event[3:0] & irq_enable[3:0]) && !(reg_wr && reg_addr == REG_IRQ_ENABLE))
			|=> ##1 irq)
		else $error("enabled pulse event did not raise interrupt");

endmodule // mpmo_top

// ### verif/mpmo_far_model.sv
// far-side model: shared ram, engine clock source and test equipment capture
`timescale 1ns/1ps
module mpmo_far_model
	import mpmo_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// shared ram read port
	input wire logic ram_rd,
	input wire logic [RAM_AW-1:0] ram_addr,
	output logic [31:0] ram_rdata,
	// test equipment
	output logic engine_clock,
	input wire logic test_output_pin,
	input wire logic test_clock,
	input wire logic cap_clr,
	output logic [139:0] cap_bits,
	output int cap_n
);
	initial begin
		ram_rdata = 32'h0;
		engine_clock = 1'b0;
		#3;
		forever #62.5 engine_clock = ~engine_clock;
	end

	// data only in the cycle after the strobe, toggling otherwise
	always @(posedge ref_clk) begin
		ram_rdata <= ram_rd ? {ram_addr, 8'h5A, ~ram_addr} : ~ram_rdata;
	end

	// equipment samples the serial line on the falling test clock
	always @(negedge test_clock or posedge cap_clr) begin
		if (cap_clr) begin
			cap_n <= 0;
			cap_bits <= '0;
		end else begin
			cap_n <= cap_n + 1;
			cap_bits <= {cap_bits[138:0], test_output_pin};
		end
	end
endmodule // mpmo_far_model

// ### verif/mpmo_top_tb.sv
// self-checking bench for the pulse and monitor output block
`timescale 1ns/1ps
`define chk(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module mpmo_top_tb;
	import mpmo_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pass_start = 1'b0;
	logic sign_valid = 1'b0;
	logic sign_real = 1'b0;
	logic sign_reactive = 1'b0;
	logic third_pulse_req = 1'b0;
	logic fourth_pulse_req = 1'b0;
	logic cap_clr = 1'b0;
	logic [31:0] reg_rdata, ram_rdata, rd;
	logic [2:0] meter_formula_select;
	logic [RAM_AW-1:0] ram_addr;
	logic ram_rd, engine_clock, test_output_pin, test_clock, irq;
	logic real_energy_output, reactive_energy_output;
	logic multipurpose_pin_six, multipurpose_pin_seven;
	logic [139:0] cap_bits, exp_bits;
	logic [11:0] mon_a [4] = '{12'h001, 12'hABC, 12'hFFF, 12'h800};
	int cap_n, n, i;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	wire logic [3:0] pins = {real_energy_output, reactive_energy_output,
		multipurpose_pin_six, multipurpose_pin_seven};

	mpmo_top i_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pass_start, .sign_valid, .sign_real, .sign_reactive, .third_pulse_req,
		.fourth_pulse_req, .meter_formula_select, .ram_rd, .ram_addr, .ram_rdata,
		.engine_clock, .test_output_pin, .test_clock, .real_energy_output,
		.reactive_energy_output, .multipurpose_pin_six, .multipurpose_pin_seven, .irq);
	mpmo_far_model i_far (.ref_clk, .ram_rd, .ram_addr, .ram_rdata, .engine_clock,
		.test_output_pin, .test_clock, .cap_clr, .cap_bits, .cap_n);

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// access tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic eng(input logic ps, input logic sv, input logic re, input logic rx);
		@(posedge ref_clk);
		pass_start <= ps;
		sign_valid <= sv;
		sign_real <= re;
		sign_reactive <= rx;
		@(posedge ref_clk);
		pass_start <= 1'b0;
		sign_valid <= 1'b0;
	endtask

	task automatic wait_lvl(input logic v);
		for (int k = 0; k < 400 && real_energy_output !== v; k++) begin
			@(posedge ref_clk);
			#1;
		end
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// test sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		rdr(REG_CTRL, rd);
		`chk("ctrl_reset", 32'h14, rd)
		`chk("pins_reset", 4'hF, pins)
		rdr(8'hFC, rd);
		`chk("unmapped", 32'h0, rd)
		for (i = 5; i >= 2; i--) begin
			wr(REG_CTRL, 32'(i) << 2);
			rdr(REG_CTRL, rd);
			`chk("ctrl_formula", 32'(i) << 2, rd)
			`chk("formula_out", 3'(i), meter_formula_select)
		end
		wr(REG_CTRL, 32'h1C);
		settle(2);
		`chk("formula_bad", 3'h2, meter_formula_select)
		// monitor: four words, flag first, then abort by disable
		for (i = 0; i < 4; i++) wr(REG_MON_ADDR0 + 8'(4 * i), 32'(mon_a[i]));
		wr(REG_CTRL, 32'h15);
		cap_clr <= 1'b1;
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		cap_clr <= 1'b0;
		for (i = 0; i < 4000 && cap_n < 140; i++) @(posedge ref_clk);
		settle(300);
		exp_bits = '0;
		for (i = 0; i < 4; i++) exp_bits = {exp_bits[104:0], 1'b1, mon_a[i], 8'h5A, ~mon_a[i], 2'b00};
		`chk("mon_bits", exp_bits, cap_bits)
		`chk("mon_count", 140, cap_n)
		`chk("mon_idle", 2'b00, {test_output_pin, test_clock})
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		settle(600);
		wr(REG_CTRL, 32'h14);
		settle(3);
		n = cap_n;
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		settle(300);
		`chk("mon_stop", n, cap_n)
		`chk("mon_off", 2'b00, {test_output_pin, test_clock})
		// real then reactive pair, spread one per slot
		eng(1'b0, 1'b1, 1'b1, 1'b0);
		eng(1'b0, 1'b1, 1'b0, 1'b1);
		wait_lvl(1'b0);
		settle(62);
		`chk("slot1", 4'h7, pins)
		settle(125);
		`chk("slot2", 4'hB, pins)
		settle(125);
		`chk("slot3", 4'hF, pins)
		rdr(REG_IRQ_STATUS, rd);
		`chk("status_pulses", 32'h3, rd & 32'h1F)
		// six back-to-back pairs overrun four slots of two bits
		wr(REG_IRQ_CLEAR, 32'h1F);
		wr(REG_IRQ_ENABLE, 32'h10);
		settle(3);
		`chk("irq_clear", 1'b0, irq)
		@(posedge ref_clk);
		sign_valid <= 1'b1;
		sign_real <= 1'b0;
		sign_reactive <= 1'b0;
		repeat (6) @(posedge ref_clk);
		sign_valid <= 1'b0;
		settle(3);
		`chk("irq_overflow", 1'b1, irq)
		wr(REG_IRQ_CLEAR, 32'h10);
		settle(3);
		`chk("irq_cleared", 1'b0, irq)
		settle(800);
		// inverted polarity, third and fourth pulses
		wr(REG_CTRL, 32'h16);
		wr(REG_IRQ_ENABLE, 32'h0);
		settle(3);
		`chk("pins_inv", 4'h0, pins)
		@(posedge ref_clk);
		third_pulse_req <= 1'b1;
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		settle(4);
		`chk("third_on", 2'b10, {multipurpose_pin_six, multipurpose_pin_seven})
		`chk("irq_masked", 1'b0, irq)
		wr(REG_IRQ_ENABLE, 32'h4);
		settle(3);
		`chk("irq_third", 1'b1, irq)
		wr(REG_IRQ_CLEAR, 32'h4);
		third_pulse_req <= 1'b0;
		fourth_pulse_req <= 1'b1;
		settle(20);
		`chk("irq_done", 1'b0, irq)
		`chk("held_pass", 2'b10, {multipurpose_pin_six, multipurpose_pin_seven})
		eng(1'b1, 1'b0, 1'b0, 1'b0);
		settle(4);
		`chk("fourth_on", 2'b01, {multipurpose_pin_six, multipurpose_pin_seven})
		rdr(REG_PULSE_STATE, rd);
		`chk("pulse_state", 32'h88, rd)
		rdr(REG_IRQ_ENABLE, rd);
		`chk("irq_enable_rb", 32'h4, rd)
		eng(1'b0, 1'b1, 1'b1, 1'b1);
		wait_lvl(1'b1);
		`chk("both_high", 2'b11, {real_energy_output, reactive_energy_output})
		tally_and_finish();
	end
endmodule // mpmo_top_tb
